// *** core/pulse_filter_map.vh ***
// Functional notes
// - Trapezoid filters set by length and gap
// - Energy is sampled peak minus baseline
// - Detect when fast filter crosses threshold
// - Piled-up events discarded, never stored
// - Fast or middle filter triggers; fast alone rejects events
// - Fast peaking 40 ns to 2.56 us
// - Slow peaking 100 ns to 164 us
// - Middle filter detects soft events, tracks baseline
// - RC variant: fast and slow only
// - Decimation 0 variant: no middle filter
// - Accepted 16-bit energies pushed into FIFO
// - Keep live, real and input-event counts
// - Live tick is sixteen clocks, 800 ns
// - Live time stops during auto-zero, reset, out-of-range
// - Pre-average 1, 4, 16 or 64 samples
// - One 14-bit converter sample per strobe
// - Auto-zero on drift; resets add settle time
// - Out-of-range time counts as dead time
// - Ramp slope follows input rate automatically
`ifndef PULSE_FILTER_MAP_VH
`define PULSE_FILTER_MAP_VH
// Register word addresses
`define A_CTRL      5'h00
`define A_FAST_LEN  5'h01
`define A_FAST_GAP  5'h02
`define A_MID_LEN   5'h03
`define A_MID_GAP   5'h04
`define A_SLOW_LEN  5'h05
`define A_SLOW_GAP  5'h06
`define A_FAST_THR  5'h07
`define A_MID_THR   5'h08
`define A_SETTLE    5'h09
`define A_SLOPE     5'h0A
`define A_STATUS    5'h0B
`define A_FIFO      5'h0C
`define A_DROPS     5'h0D
`define A_PILEUPS   5'h0E
`define A_LIVE_LO   5'h10
`define A_LIVE_HI   5'h11
`define A_REAL_LO   5'h12
`define A_REAL_HI   5'h13
`define A_EVT_LO    5'h14
`define A_EVT_HI    5'h15
// Field positions
`define F_RUN       0
`define F_ST_AZ     12
`define F_ST_EMPTY  13
`define F_ST_FULL   14
`define F_ST_RUN    15
// Reset values
`define R_LEN       8'h04
`define R_GAP       8'h02
`define R_THR       16'h0100
`define R_SETTLE    16'h0028
`define R_SLOPE     10'h200
// Timing
`define CLK_MHZ     20
`define AZ_TIME_NS  1000
`define AZ_CYC      ((`AZ_TIME_NS * `CLK_MHZ + 999) / 1000)
`define LT_TICK_NS  800
`define LT_DIV      ((`LT_TICK_NS * `CLK_MHZ) / 1000)
`define FAST_PK_MIN_NS 40
`define FAST_PK_MAX_NS 2560
`define SLOW_PK_MIN_NS 100
`define SLOW_PK_MAX_NS 164000
`define ADC_MAX     14'h3FFF
`define ADC_MIN     14'h0000
`endif

// *** core/pulse_filter_processor.v ***
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "pulse_filter_map.vh"
module pulse_filter_processor
#(
  parameter DECIM      = 2,
  parameter RC_VARIANT = 0
)
(
  input  wire        clock,
  input  wire        rst_b,
  input  wire [4:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire [13:0] adc_data,
  input  wire        adc_valid,
  input  wire        preamp_reset,
  output reg         autozero,
  output reg         drift_high_event,
  output reg         drift_low_event,
  output reg  [9:0]  ramp_slope_setting
);
  localparam HAS_MID = (RC_VARIANT == 0) && (DECIM != 0);
  localparam NAVG    = 1 << DECIM;
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg  [15:0] ctrl_q;
  reg  [23:0] len_q;
  reg  [23:0] gap_q;
  reg  [15:0] fthr_q;
  reg  [15:0] mthr_q;
  reg  [15:0] settle_q;
  reg  [19:0] acc_q;
  reg  [6:0]  acnt_q;
  reg  [13:0] x_q;
  reg         dec_stb_q;
  reg  [13:0] hist [0:1023];
  reg  [9:0]  wp_q;
  wire [71:0] y_all;
  reg         fover_q;
  reg         mover_q;
  reg  [23:0] base_q;
  reg  [1:0]  state_q;
  reg  [9:0]  pk_q;
  reg         pile_q;
  reg  [15:0] fifo_mem [0:15];
  reg  [4:0]  fwp_q;
  reg  [4:0]  frp_q;
  reg  [15:0] drops_q;
  reg  [15:0] piles_q;
  reg  [31:0] live_q;
  reg  [31:0] real_q;
  reg  [31:0] evt_q;
  reg  [3:0]  pre_q;
  reg  [15:0] az_q;
  reg         oor_q;

  wire        run = ctrl_q[`F_RUN];
  wire        wr_cfg = reg_wr & ~run;
  wire [19:0] acc_sum = acc_q + {6'h00, adc_data};
  wire        oor_now = (adc_data == `ADC_MAX) | (adc_data == `ADC_MIN);
  wire        dead = autozero | oor_q | preamp_reset;
  wire        live = run & ~dead;
  wire [23:0] fast_y = y_all[23:0];
  wire [23:0] mid_y = y_all[47:24];
  wire [23:0] slow_y = y_all[71:48];
  wire        fhit = $signed(fast_y) > $signed({8'h00, fthr_q});
  wire        mhit = HAS_MID && ($signed(mid_y) > $signed({8'h00, mthr_q}));
  wire        ftrig = dec_stb_q & live & fhit & ~fover_q;
  wire        mtrig = dec_stb_q & live & mhit & ~mover_q;
  wire [23:0] bsrc = HAS_MID ? mid_y : slow_y;
  wire [23:0] bdelta = bsrc - base_q;
  wire [23:0] diff = slow_y - base_q;
  // Aim at mid flat-top; trigger latency already spends two samples
  wire [9:0]  pk_mid = {2'b00, len_q[23:16]} + {3'b000, gap_q[23:17]};
  wire [9:0]  pk_len = (pk_mid > 10'h002) ? pk_mid - 10'h002 : 10'h000;
  wire        f_full = (fwp_q[3:0] == frp_q[3:0]) & (fwp_q[4] != frp_q[4]);
  wire        f_empty = (fwp_q == frp_q);
  wire        pop = reg_rd & (reg_addr == `A_FIFO) & ~f_empty;
  wire        done = (state_q == ST_WAIT) & dec_stb_q & (pk_q == 10'h000);
  wire        accept = done & ~pile_q;
  wire [15:0] energy;
  wire [31:0] az_short = `AZ_CYC;
  wire [31:0] az_long = `AZ_CYC + settle_q;

  // Negative results clamp to zero, large ones saturate
  assign energy = diff[23] ? 16'h0000 : (|diff[22:16] ? 16'hFFFF : diff[15:0]);

  // Configuration registers; only the control word moves during a run
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      ctrl_q <= 16'h0000;
      len_q <= {`R_LEN, `R_LEN, `R_LEN};
      gap_q <= {`R_GAP, `R_GAP, `R_GAP};
      fthr_q <= `R_THR;
      mthr_q <= `R_THR;
      settle_q <= `R_SETTLE;
    end
    else
    begin
      if (reg_wr && reg_addr == `A_CTRL)
        ctrl_q <= reg_wdata;
      if (wr_cfg)
      begin
        case (reg_addr)
          `A_FAST_LEN: len_q[7:0] <= reg_wdata[7:0];
          `A_FAST_GAP: gap_q[7:0] <= reg_wdata[7:0];
          `A_MID_LEN:  len_q[15:8] <= reg_wdata[7:0];
          `A_MID_GAP:  gap_q[15:8] <= reg_wdata[7:0];
          `A_SLOW_LEN: len_q[23:16] <= reg_wdata[7:0];
          `A_SLOW_GAP: gap_q[23:16] <= reg_wdata[7:0];
          `A_FAST_THR: fthr_q <= reg_wdata;
          `A_MID_THR:  mthr_q <= reg_wdata;
          `A_SETTLE:   settle_q <= reg_wdata;
          default:     ;
        endcase
      end
    end
  end

  // Pre-averaging: sum 2^DECIM samples, then shift down
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      acc_q <= 20'h00000;
      acnt_q <= 7'h00;
      x_q <= 14'h0000;
      dec_stb_q <= 1'b0;
    end
    else
    begin
      dec_stb_q <= 1'b0;
      if (adc_valid)
      begin
        if (acnt_q == NAVG - 1)
        begin
          x_q <= acc_sum[DECIM +: 14];
          dec_stb_q <= run;
          acc_q <= 20'h00000;
          acnt_q <= 7'h00;
        end
        else
        begin
          acc_q <= acc_sum;
          acnt_q <= acnt_q + 7'h01;
        end
      end
    end
  end

  // Sample history; filled with the live sample while idle, so a run
  // that starts on a steady level sees no false step at its taps
  always @(posedge clock)
  begin
    if (!rst_b)
      wp_q <= 10'h000;
    else if (!run || dec_stb_q)
      wp_q <= wp_q + 10'h001;
  end

  always @(posedge clock)
  begin
    if (!run)
      hist[wp_q] <= x_q;
    else if (dec_stb_q)
      hist[wp_q] <= x_q;
  end

  // Fast, middle and slow trapezoids share one history
  genvar f;
  generate
    for (f = 0; f < 3; f = f + 1)
    begin : trap
      wire [9:0]  d1 = {2'b00, len_q[f*8 +: 8]};
      wire [9:0]  d2 = d1 + {2'b00, gap_q[f*8 +: 8]};
      wire [9:0]  d3 = d2 + d1;
      wire [13:0] t1 = hist[wp_q - d1];
      wire [13:0] t2 = hist[wp_q - d2];
      wire [13:0] t3 = hist[wp_q - d3];
      reg  [23:0] y_q;
      // Rise over length, flat over gap, fall over length
      always @(posedge clock)
      begin
        if (!rst_b || !run || (f == 1 && !HAS_MID))
          y_q <= 24'h000000;
        else if (dec_stb_q)
          y_q <= y_q + {10'h000, x_q} - {10'h000, t1}
                 - {10'h000, t2} + {10'h000, t3};
      end
      assign y_all[f*24 +: 24] = y_q;
    end
  endgenerate

  // Threshold crossing memory and baseline tracking
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      fover_q <= 1'b0;
      mover_q <= 1'b0;
      base_q <= 24'h000000;
    end
    else if (dec_stb_q)
    begin
      fover_q <= fhit;
      mover_q <= mhit;
      // Slow averaging only between events keeps pulses out of it
      if (state_q == ST_IDLE && !fhit && !mhit)
        base_q <= base_q + {{4{bsrc < base_q}}, bdelta[23:4]};
    end
  end

  // Event sequencer: wait to the slow peak, reject on a second fast trigger
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      pk_q <= 10'h000;
      pile_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (ftrig || mtrig)
          begin
            state_q <= ST_WAIT;
            pk_q <= pk_len;
            pile_q <= 1'b0;
          end
        end
        ST_WAIT:
        begin
          if (ftrig)
            pile_q <= 1'b1;
          if (!run)
            state_q <= ST_IDLE;
          else if (dec_stb_q)
          begin
            if (pk_q == 10'h000)
              state_q <= ST_IDLE;
            else
              pk_q <= pk_q - 10'h001;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Energy FIFO; a full FIFO drops the event rather than stall
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      fwp_q <= 5'h00;
      frp_q <= 5'h00;
      drops_q <= 16'h0000;
      piles_q <= 16'h0000;
    end
    else
    begin
      if (accept && !f_full)
        fwp_q <= fwp_q + 5'h01;
      if (accept && f_full)
        drops_q <= drops_q + 16'h0001;
      if (done && pile_q)
        piles_q <= piles_q + 16'h0001;
      if (pop)
        frp_q <= frp_q + 5'h01;
    end
  end

  always @(posedge clock)
  begin
    if (accept && !f_full)
      fifo_mem[fwp_q[3:0]] <= energy;
  end

  // Run statistics; live and real share the divide-by-16 tick
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      pre_q <= 4'h0;
      live_q <= 32'h00000000;
      real_q <= 32'h00000000;
      evt_q <= 32'h00000000;
    end
    else
    begin
      if (run)
        pre_q <= pre_q + 4'h1;
      if (run && pre_q == `LT_DIV - 1)
      begin
        real_q <= real_q + 32'h00000001;
        if (live)
          live_q <= live_q + 32'h00000001;
      end
      if (ftrig || (mtrig && state_q == ST_IDLE))
        evt_q <= evt_q + 32'h00000001;
    end
  end

  // Conditioner control: auto-zero on drift, longer after a reset
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      az_q <= 16'h0000;
      oor_q <= 1'b0;
      autozero <= 1'b0;
      drift_high_event <= 1'b0;
      drift_low_event <= 1'b0;
      ramp_slope_setting <= `R_SLOPE;
    end
    else
    begin
      drift_high_event <= 1'b0;
      drift_low_event <= 1'b0;
      if (adc_valid)
        oor_q <= oor_now;
      if (preamp_reset)
        az_q <= az_long[15:0];
      else if (adc_valid && oor_now && az_q == 16'h0000)
      begin
        az_q <= az_short[15:0];
        drift_high_event <= adc_data == `ADC_MAX;
        drift_low_event <= adc_data == `ADC_MIN;
        // Frequent drifts mean the slope no longer matches the rate
        if (adc_data == `ADC_MAX && ramp_slope_setting != 10'h3FF)
          ramp_slope_setting <= ramp_slope_setting + 10'h001;
        else if (adc_data == `ADC_MIN && ramp_slope_setting != 10'h000)
          ramp_slope_setting <= ramp_slope_setting - 10'h001;
      end
      else if (az_q != 16'h0000)
        az_q <= az_q - 16'h0001;
      if (wr_cfg && reg_addr == `A_SLOPE)
        ramp_slope_setting <= reg_wdata[9:0];
      autozero <= preamp_reset | (az_q > 16'h0001) |
                  (adc_valid & oor_now & az_q == 16'h0000);
    end
  end

  // Read data stands in the cycle after the strobe only
  always @(posedge clock)
  begin
    if (!rst_b || !reg_rd)
      reg_rdata <= 16'h0000;
    else
    begin
      case (reg_addr)
        `A_CTRL:     reg_rdata <= ctrl_q;
        `A_FAST_LEN: reg_rdata <= {8'h00, len_q[7:0]};
        `A_FAST_GAP: reg_rdata <= {8'h00, gap_q[7:0]};
        `A_MID_LEN:  reg_rdata <= {8'h00, len_q[15:8]};
        `A_MID_GAP:  reg_rdata <= {8'h00, gap_q[15:8]};
        `A_SLOW_LEN: reg_rdata <= {8'h00, len_q[23:16]};
        `A_SLOW_GAP: reg_rdata <= {8'h00, gap_q[23:16]};
        `A_FAST_THR: reg_rdata <= fthr_q;
        `A_MID_THR:  reg_rdata <= mthr_q;
        `A_SETTLE:   reg_rdata <= settle_q;
        `A_SLOPE:    reg_rdata <= {6'h00, ramp_slope_setting};
        `A_STATUS:   reg_rdata <= {run, f_full, f_empty, autozero,
                                   7'h00, fwp_q - frp_q};
        `A_FIFO:     reg_rdata <= f_empty ? 16'h0000 : fifo_mem[frp_q[3:0]];
        `A_DROPS:    reg_rdata <= drops_q;
        `A_PILEUPS:  reg_rdata <= piles_q;
        `A_LIVE_LO:  reg_rdata <= live_q[15:0];
        `A_LIVE_HI:  reg_rdata <= live_q[31:16];
        `A_REAL_LO:  reg_rdata <= real_q[15:0];
        `A_REAL_HI:  reg_rdata <= real_q[31:16];
        `A_EVT_LO:   reg_rdata <= evt_q[15:0];
        `A_EVT_HI:   reg_rdata <= evt_q[31:16];
        default:     reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule

// *** sim/pfp_chk.sv ***
`timescale 1ns/1ps
`include "pulse_filter_map.vh"
module pfp_chk
(
  input wire        clock,
  input wire        rst_b,
  input wire        reg_rd,
  input wire [4:0]  reg_addr,
  input wire [15:0] reg_rdata,
  input wire [13:0] adc_data,
  input wire        adc_valid,
  input wire        preamp_reset,
  input wire        autozero,
  input wire        drift_high_event,
  input wire        drift_low_event
);
  reg [7:0] az_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Length of the current auto-zero run
  always @(posedge clock)
    if (!rst_b)
      az_q <= 8'h00;
    else
      az_q <= autozero ? az_q + 8'h01 : 8'h00;
  a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_hi_cause: assert property (
    drift_high_event |-> $past(adc_valid && adc_data == 14'h3FFF))
    else $error("high drift without top sample");
  a_lo_cause: assert property (
    drift_low_event |-> $past(adc_valid && adc_data == 14'h0000))
    else $error("low drift without bottom sample");
  a_drift_excl: assert property (!(drift_high_event && drift_low_event))
    else $error("both drift pulses at once");
  a_hi_pulse: assert property (drift_high_event |=> !drift_high_event)
    else $error("high drift pulse too long");
  a_drift_az: assert property ((drift_high_event || drift_low_event) |-> autozero)
    else $error("drift without auto-zero");
  a_az_min: assert property ($fell(autozero) |-> az_q >= `AZ_CYC)
    else $error("auto-zero too short");
  a_preamp_az: assert property ($rose(preamp_reset) |-> ##[1:2] autozero)
    else $error("no auto-zero on preamp reset");
  // Main scenarios reached
  cover property (drift_high_event);
  cover property (drift_low_event);
  cover property ($fell(autozero) && az_q > 8'h16);
endmodule
bind pulse_filter_processor pfp_chk chk_i (.clock, .rst_b, .reg_rd, .reg_addr, .reg_rdata,
  .adc_data, .adc_valid, .preamp_reset, .autozero, .drift_high_event, .drift_low_event);

// *** sim/dsp_model.sv ***
`timescale 1ns/1ps
module dsp_model
(
  input wire        clock,
  input wire [15:0] reg_rdata,
  output reg [4:0]  reg_addr,
  output reg [15:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd
);
  // Idle bus at time zero
  initial
  begin
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse, so stale values never look valid
  task wr(input [4:0] a, input [15:0] d);
  begin
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  end
  endtask
  task rd(input [4:0] a, output [15:0] q);
  begin
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clock);
    q = reg_rdata;
  end
  endtask
endmodule

// *** sim/xray_pulse_filter_processor_tb.sv ***
`timescale 1ns/1ps
module xray_pulse_filter_processor_tb;
  reg         clock;
  reg         rst_b;
  reg         adc_valid;
  reg         preamp_reset;
  reg         rd_seen;
  reg  [13:0] adc_data;
  reg  [13:0] lvl;
  reg  [13:0] h;
  reg  [15:0] q;
  reg  [16:0] n;
  reg  [16:0] exp_q[$];
  wire [4:0]  reg_addr;
  wire [15:0] reg_wdata;
  wire [15:0] reg_rdata;
  wire        reg_wr;
  wire        reg_rd;
  wire        autozero;
  wire        drift_high_event;
  wire        drift_low_event;
  wire [9:0]  ramp_slope_setting;
  integer     n_fail;
  integer     total_checks;
  integer     i;
  integer     az;
  integer     e1;
  integer     e2;
  integer     rl;
  integer     lv;
  integer     d0;
  // Decimation 0 build keeps the runs short
  pulse_filter_processor #(.DECIM(0), .RC_VARIANT(0)) pulse_filter_processor_i (
    .clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .adc_data, .adc_valid, .preamp_reset, .autozero, .drift_high_event, .drift_low_event,
    .ramp_slope_setting);
  dsp_model dsp_model_i (.clock, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  task ck(input [15:0] e, input [15:0] g);
  begin
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  end
  endtask
  task rx(input [4:0] a, input [15:0] e);
  begin
    exp_q.push_back({1'b1, e});
    dsp_model_i.rd(a, q);
  end
  endtask
  task rv(input [4:0] a, output integer v);
  begin
    exp_q.push_back(17'h00000);
    dsp_model_i.rd(a, q);
    v = q;
  end
  endtask
  task step(input [13:0] s, input integer w);
  begin
    lvl = lvl + s;
    @(posedge clock);
    adc_data <= lvl;
    repeat (w) @(posedge clock);
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // Clock, 50 ns period
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Read data is compared in the one cycle it stands
  always @(posedge clock)
    rd_seen <= reg_rd;
  always @(negedge clock)
    if (rd_seen)
    begin
      n = exp_q.pop_front();
      if (n[16])
        ck(n[15:0], reg_rdata);
    end
  // Watchdog, about two and a half times the expected run
  initial
  begin
    #2000000;
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    rst_b = 1'b0;
    adc_valid = 1'b1;
    preamp_reset = 1'b0;
    lvl = 14'h1000;
    adc_data = lvl;
    void'($urandom(32'h4BBC));
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    repeat (1030) @(posedge clock);
    ck(16'h0200, {6'h00, ramp_slope_setting});
    rx(5'h01, 16'h0004);
    rx(5'h06, 16'h0002);
    rx(5'h07, 16'h0100);
    rx(5'h09, 16'h0028);
    rx(5'h0B, 16'h2000);
    rx(5'h10, 16'h0000);
    rx(5'h1F, 16'h0000);
    rx(5'h0C, 16'h0000);
    $display("reset values done");
    dsp_model_i.wr(5'h01, 16'h0002);
    dsp_model_i.wr(5'h02, 16'h0000);
    dsp_model_i.wr(5'h05, 16'h0010);
    dsp_model_i.wr(5'h06, 16'h0004);
    dsp_model_i.wr(5'h07, 16'h0040);
    dsp_model_i.wr(5'h09, 16'h0004);
    dsp_model_i.wr(5'h00, 16'h0001);
    dsp_model_i.wr(5'h01, 16'h0007);
    rx(5'h01, 16'h0002);
    rx(5'h06, 16'h0004);
    rx(5'h0B, 16'hA000);
    $display("settings done");
    repeat (1600) @(posedge clock);
    rv(5'h12, rl);
    rv(5'h10, lv);
    ck(16'h0001, {15'h0000, rl >= 99 && rl <= 103});
    ck(16'h0001, {15'h0000, rl - lv <= 1});
    $display("counters done");
    h = 14'h0200 + $urandom % 512;
    step(h, 1100);
    step(h << 1, 1100);
    rx(5'h14, 16'h0002);
    rx(5'h0B, 16'h8002);
    rv(5'h0C, e1);
    rv(5'h0C, e2);
    ck(16'h0001, {15'h0000, e1 > 0 && e2 >= 2 * e1 - 8 && e2 <= 2 * e1 + 8});
    $display("energy done");
    step(h, 10);
    step(h, 1100);
    rx(5'h14, 16'h0004);
    rx(5'h0E, 16'h0001);
    rx(5'h0B, 16'hA000);
    $display("pileup done");
    for (i = 0; i < 17; i = i + 1)
      step(14'h0080 + $urandom % 64, 600);
    rx(5'h0B, 16'hC010);
    rx(5'h0D, 16'h0001);
    rx(5'h14, 16'h0015);
    for (i = 0; i < 16; i = i + 1)
      rv(5'h0C, e1);
    rx(5'h0B, 16'hA000);
    $display("fifo full done");
    rv(5'h12, rl);
    rv(5'h10, lv);
    d0 = rl - lv;
    @(posedge clock);
    adc_data <= 14'h3FFF;
    @(posedge clock);
    adc_data <= lvl;
    repeat (40) @(posedge clock);
    ck(16'h0201, {6'h00, ramp_slope_setting});
    adc_data <= 14'h0000;
    @(posedge clock);
    adc_data <= lvl;
    repeat (40) @(posedge clock);
    ck(16'h0200, {6'h00, ramp_slope_setting});
    az = 0;
    preamp_reset <= 1'b1;
    repeat (3) @(posedge clock);
    preamp_reset <= 1'b0;
    for (i = 0; i < 60; i = i + 1)
      @(negedge clock) az = az + autozero;
    ck(16'h0001, {15'h0000, az >= 24 && az <= 30});
    rv(5'h12, rl);
    rv(5'h10, lv);
    ck(16'h0001, {15'h0000, rl - lv - d0 >= 3 && rl - lv - d0 <= 7});
    $display("conditioner done");
    print_verdict;
  end
endmodule
